//--- design/lhd_pkg.sv
// Package: constants shared by the LED head shift/latch driver
`default_nettype none
package lhd_pkg;
    // Register chain length and drive-output count
    localparam int LHD_WIDTH = 64;
    // Reset value of shift register, latch and outputs
    localparam logic [63:0] LHD_RST_DATA = 64'h0000_0000_0000_0000;
    // Drive-current mode encodings
    typedef enum logic [1:0] {
        LHD_MODE_NONE = 2'b00,
        LHD_MODE_NOM = 2'b01,
        LHD_MODE_DOWN = 2'b10,
        LHD_MODE_UP = 2'b11
    } lhd_mode_e;
endpackage : lhd_pkg
`default_nettype wire

//--- design/lhd_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module lhd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Asynchronous pins and their synchronised copy
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    // First stage, read only by second stage
    logic [W-1:0] meta_ff;

    // Two flops in series against metastability
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            pin_out <= '0;
        end else begin
            meta_ff <= pin_in;
            pin_out <= meta_ff;
        end
    end
endmodule : lhd_sync
`default_nettype wire

//--- design/lhd_top.sv
// LED head driver: 64-bit shift register, latch, blanking and trim mode
//
// Overview of operation
// - Falling shift_clock edge shifts in serial data
// - Latch follows shift register during active gate
// - Both trim pads low select mode 1
// - Down-trim selects mode 2; up-trim mode 3
`timescale 1ns/1ps
`default_nettype none
module lhd_top
    import lhd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Serial link from the controller
    input wire logic shift_clock,
    input wire logic serial_data_in,
    input wire logic latch_gate,
    input wire logic gate_pol_sel,
    // Output control pads
    input wire logic strobe_n,
    input wire logic trim_up_pad,
    input wire logic trim_down_pad,
    // LED drive and mode
    output logic [LHD_WIDTH-1:0] led_drive_outputs,
    output var lhd_mode_e drive_mode_ff,
    // Cascade repeats
    output logic serial_data_out,
    output logic clock_repeat_out,
    output logic gate_repeat_out
);
    // Synchronised copies of all pins
    logic [6:0] pins_s;
    logic sclk_s;
    logic sdi_s;
    logic gate_s;
    logic pol_s;
    logic strobe_n_s;
    logic up_s;
    logic down_s;
    // Previous shift clock level, for edge detection
    logic sclk_d_ff;
    // Shift register and latch
    logic [LHD_WIDTH-1:0] shreg_ff;
    logic [LHD_WIDTH-1:0] latch_ff;
    logic [LHD_WIDTH-1:0] nxt_drive;
    logic gate_active;
    logic sclk_fall;

    // Every pin passes two flops before use
    lhd_sync #(.W(7)) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin_in({shift_clock, serial_data_in, latch_gate, gate_pol_sel,
                 strobe_n, trim_up_pad, trim_down_pad}),
        .pin_out(pins_s)
    );
    assign {sclk_s, sdi_s, gate_s, pol_s, strobe_n_s, up_s, down_s} = pins_s;

    // Edge detect on the synchronised clock only
    assign sclk_fall = sclk_d_ff & ~sclk_s;
    // Gate active level follows polarity select
    assign gate_active = ~(gate_s ^ pol_s);

    // Shift clock history
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
        end
    end

    // Raw pin samples, as the first sync flop takes them
    sequence s_pin_fall;
        shift_clock ##1 !shift_clock;
    endsequence

    sequence s_pin_rise;
        !shift_clock ##1 shift_clock;
    endsequence

    // Two sync stages put the strobe two edges behind the pin samples
    sequence s_strobe_late;
        ##2 sclk_fall;
    endsequence

    // A pin fall caught by the sync must never be lost
    property p_fall_seen;
        @(posedge ref_clk) disable iff (!rstn)
        s_pin_fall |-> s_strobe_late;
    endproperty
    chk_fall_seen: assert property (p_fall_seen) else $error("fall lost");

    // A rising pin edge never produces a shift strobe
    property p_rise_quiet;
        @(posedge ref_clk) disable iff (!rstn)
        s_pin_rise |-> ##2 !sclk_fall;
    endproperty
    chk_rise_quiet: assert property (p_rise_quiet) else $error("shift on rise");

    // Shift on falling edge, hold otherwise; bit 63 enters first
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shreg_ff <= LHD_RST_DATA;
        end else if (sclk_fall) begin
            shreg_ff <= {shreg_ff[LHD_WIDTH-2:0], sdi_s};
        end
    end

    // Transparent latch modelled as a clocked copy while gate active
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            latch_ff <= LHD_RST_DATA;
        end else if (gate_active) begin
            latch_ff <= shreg_ff;
        end
    end

    // Output gating per bit
    genvar gi;
    generate
        for (gi = 0; gi < LHD_WIDTH; gi++) begin : g_drv
            // Off when blanked, else follows latched bit
            assign nxt_drive[gi] = ~strobe_n_s & latch_ff[gi];
        end
    endgenerate

    // Drive outputs registered
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            led_drive_outputs <= LHD_RST_DATA;
        end else begin
            led_drive_outputs <= nxt_drive;
        end
    end

    // Trim pad decode; both high is undefined and reported as none
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            drive_mode_ff <= LHD_MODE_NOM;
        end else begin
            case ({up_s, down_s})
                2'b00: drive_mode_ff <= LHD_MODE_NOM;
                2'b01: drive_mode_ff <= LHD_MODE_DOWN;
                2'b10: drive_mode_ff <= LHD_MODE_UP;
                default: drive_mode_ff <= LHD_MODE_NONE;
            endcase
        end
    end

    // Cascade repeats; chain length and polarity are the board's job
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            serial_data_out <= 1'b0;
            clock_repeat_out <= 1'b0;
            gate_repeat_out <= 1'b0;
        end else begin
            serial_data_out <= shreg_ff[LHD_WIDTH-1];
            clock_repeat_out <= sclk_s;
            gate_repeat_out <= gate_s;
        end
    end

    // Chain outputs trail the register end and the synced pins by one edge
    property p_chain_sdo;
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> serial_data_out == $past(shreg_ff[LHD_WIDTH-1]);
    endproperty
    chk_chain_sdo: assert property (p_chain_sdo) else $error("serial out wrong");

    property p_chain_clk;
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> clock_repeat_out == $past(sclk_s);
    endproperty
    chk_chain_clk: assert property (p_chain_clk) else $error("clock repeat wrong");

    property p_chain_gate;
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> gate_repeat_out == $past(gate_s);
    endproperty
    chk_chain_gate: assert property (p_chain_gate) else $error("gate repeat wrong");

    // Shift happens on falling edge only
    property p_shift;
        @(posedge ref_clk) disable iff (!rstn)
        sclk_fall |=> shreg_ff == {$past(shreg_ff[LHD_WIDTH-2:0]), $past(sdi_s)};
    endproperty
    chk_shift_on_fall: assert property (p_shift) else $error("shift wrong");

    property p_hold;
        @(posedge ref_clk) disable iff (!rstn)
        !sclk_fall |=> $stable(shreg_ff);
    endproperty
    chk_shift_hold: assert property (p_hold) else $error("shift moved");

    // Latch behaviour against gate level
    property p_latch;
        @(posedge ref_clk) disable iff (!rstn)
        (gate_s == pol_s) |=> latch_ff == $past(shreg_ff);
    endproperty
    chk_latch_load: assert property (p_latch) else $error("latch not loaded");

    property p_latch_hold;
        @(posedge ref_clk) disable iff (!rstn)
        (gate_s != pol_s) |=> $stable(latch_ff);
    endproperty
    chk_latch_hold: assert property (p_latch_hold) else $error("latch moved");

    // Mode decoding
    property p_mode1;
        @(posedge ref_clk) disable iff (!rstn)
        (!up_s && !down_s) |=> drive_mode_ff == LHD_MODE_NOM;
    endproperty
    chk_mode_nominal: assert property (p_mode1) else $error("mode 1 wrong");

    property p_mode2;
        @(posedge ref_clk) disable iff (!rstn)
        (!up_s && down_s) |=> drive_mode_ff == LHD_MODE_DOWN;
    endproperty
    chk_mode_down: assert property (p_mode2) else $error("mode 2 wrong");

    property p_mode3;
        @(posedge ref_clk) disable iff (!rstn)
        (up_s && !down_s) |=> drive_mode_ff == LHD_MODE_UP;
    endproperty
    chk_mode_up: assert property (p_mode3) else $error("mode 3 wrong");

    // Both pads high is outside the table and reads as none
    property p_mode_none;
        @(posedge ref_clk) disable iff (!rstn)
        (up_s && down_s) |=> drive_mode_ff == LHD_MODE_NONE;
    endproperty
    chk_mode_none: assert property (p_mode_none) else $error("mode none wrong");

    // Blanking and data gating
    property p_blank;
        @(posedge ref_clk) disable iff (!rstn)
        strobe_n_s |=> led_drive_outputs == LHD_RST_DATA;
    endproperty
    chk_blank_off: assert property (p_blank) else $error("blank ignored");

    property p_drive;
        @(posedge ref_clk) disable iff (!rstn)
        !strobe_n_s |=> led_drive_outputs == $past(latch_ff);
    endproperty
    chk_drive_data: assert property (p_drive) else $error("drive mismatch");
endmodule : lhd_top
`default_nettype wire

//--- tb/lhd_ctrl_model.sv
// Printer controller model: serial data, shift clock and latch gate
`timescale 1ns/1ps
`default_nettype none
module lhd_ctrl_model (
    // Clock and polarity
    input wire logic ref_clk,
    input wire logic gate_pol_sel,
    // Serial link to the driver
    output logic shift_clock,
    output logic serial_data_in,
    output var logic latch_gate
);
    logic gate_on = 1'b0; // Gate wanted active
    // Active level follows polarity select, so a pol change never fires it
    assign latch_gate = gate_on ? gate_pol_sel : ~gate_pol_sel;
    // Clock idles high and still between frames
    initial begin
        shift_clock = 1'b1;
        serial_data_in = 1'b0;
    end
    // First bit out is bit 63; hp cycles low and hp+1 high keeps setup and hold
    // Bit period of 2*hp+1 ref_clk cycles, far below the chain's top rate
    task automatic send(input logic [63:0] w, input int hp);
        for (int i = 63; i >= 0; i--) begin
            @(posedge ref_clk) serial_data_in <= w[i];
            repeat (hp) @(posedge ref_clk);
            shift_clock <= 1'b0;
            // Hold ends one cycle after the fall; line then scrambled
            @(posedge ref_clk) serial_data_in <= ~w[i];
            repeat (hp - 1) @(posedge ref_clk);
            shift_clock <= 1'b1;
        end
    endtask : send
    // Gate pulse, only after shifting is over
    task automatic pulse(input int n);
        @(posedge ref_clk) gate_on <= 1'b1;
        repeat (n) @(posedge ref_clk);
        gate_on <= 1'b0;
    endtask : pulse
endmodule : lhd_ctrl_model
`default_nettype wire

//--- tb/lhd_top_tb_top.sv
// Testbench top for the LED head shift/latch driver
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module lhd_top_tb_top;
    import lhd_pkg::*;
    localparam logic [63:0] P1 = 64'hA5C3_0F96_8001_7E24; // Two unlike patterns
    localparam logic [63:0] P2 = 64'h5A3C_F069_7FFE_81DB;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic pol = 1'b1; // Gate active high first
    logic strobe_n = 1'b0;
    logic trim_up_pad = 1'b0;
    logic trim_down_pad = 1'b0;
    logic sclk, sdi, gate, sdo;
    logic crep, grep; // Cascade clock and gate repeats
    logic [63:0] led;
    lhd_mode_e drive_mode_ff;
    int bad_count = 0;
    int checks_done = 0;
    lhd_ctrl_model ctl (.ref_clk(ref_clk), .gate_pol_sel(pol), .shift_clock(sclk),
        .serial_data_in(sdi), .latch_gate(gate));
    lhd_top DUT (.ref_clk(ref_clk), .rstn(rstn), .shift_clock(sclk), .serial_data_in(sdi),
        .latch_gate(gate), .gate_pol_sel(pol), .strobe_n(strobe_n), .trim_up_pad(trim_up_pad),
        .trim_down_pad(trim_down_pad), .led_drive_outputs(led), .drive_mode_ff(drive_mode_ff),
        .serial_data_out(sdo), .clock_repeat_out(crep), .gate_repeat_out(grep));
    // 50 ns clock
    initial forever #25 ref_clk = ~ref_clk;
    // Wait n edges, then sample on the falling edge where outputs are settled
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : wt
    // Fast shift, gate, outputs show the word
    task automatic t_load();
        ctl.send(P1, 4);
        ctl.pulse(4);
        wt(8);
        `CHK(led, P1)
        $display("t_load done");
    endtask : t_load
    // Slow shift without gate: latch holds, chain end shows first bit
    task automatic t_hold();
        ctl.send(P2, 9);
        wt(8);
        `CHK(led, P1)
        `CHK(sdo, P2[63])
        $display("t_hold done");
    endtask : t_hold
    // Gate active low once polarity select is low
    task automatic t_pol();
        @(posedge ref_clk) pol <= 1'b0;
        wt(6);
        `CHK(led, P1)
        `CHK(grep, gate)
        ctl.pulse(4);
        wt(8);
        `CHK(led, P2)
        $display("t_pol done");
    endtask : t_pol
    // Blanking forces all off, release restores
    task automatic t_blank();
        @(posedge ref_clk) strobe_n <= 1'b1;
        wt(6);
        `CHK(led, 64'h0000_0000_0000_0000)
        @(posedge ref_clk) strobe_n <= 1'b0;
        wt(6);
        `CHK(led, P2)
        $display("t_blank done");
    endtask : t_blank
    // Trim pad table: nominal, down, up, then both high reads as none
    task automatic t_trim();
        lhd_mode_e m;
        for (int i = 0; i < 4; i++) begin
            case (i)
                0: m = LHD_MODE_NOM;
                1: m = LHD_MODE_DOWN;
                2: m = LHD_MODE_UP;
                default: m = LHD_MODE_NONE;
            endcase
            @(posedge ref_clk) {trim_up_pad, trim_down_pad} <= 2'(i);
            wt(6);
            `CHK(drive_mode_ff, m)
        end
        $display("t_trim done");
    endtask : t_trim
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        repeat (15) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(crep, 1'b0)
        @(posedge ref_clk) rstn <= 1'b1;
        wt(4);
        `CHK(led, 64'h0000_0000_0000_0000)
        `CHK(drive_mode_ff, LHD_MODE_NOM)
        `CHK(crep, sclk)
        `CHK(grep, gate)
        t_load();
        t_hold();
        t_pol();
        t_blank();
        t_trim();
        finish_test();
    end
    // Watchdog, well past the expected 1900 or so cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        bad_count++;
        finish_test();
    end
endmodule : lhd_top_tb_top
`default_nettype wire
